// file: dprc_bank.sv
module dprc_bank (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Commands to this bank
  input wire logic i_act,
  input wire logic i_pre,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_ap,
  input wire logic i_ref_done,
  // Bank state
  output logic o_open,
  output logic o_ready
);
  import dprc_pkg::*;

  dprc_bank_t st_q, st_d;
  logic [TW-1:0] tmr_q, tmr_d, rst_q, rst_d;

  // Auto precharge waits for both restore and access end
  wire tmr_zero = (tmr_q == '0);
  wire [TW-1:0] ap_dly = i_wr ? AP_WR_LD : AP_RD_LD;
  wire [TW-1:0] ap_load = (rst_q > ap_dly) ? rst_q : ap_dly; // R6

  // Next state
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_zero ? tmr_q : tmr_q - 1'b1;
    rst_d = (rst_q == '0) ? rst_q : rst_q - 1'b1;
    unique case (st_q)
      DPRC_IDLE: if (i_act) begin // R24
        st_d = DPRC_OPEN;
        rst_d = RESTORE_LD;
      end
      DPRC_OPEN: if ((i_rd || i_wr) && i_ap) begin // R5
        st_d = DPRC_APRE;
        tmr_d = ap_load; // R6
      end
      DPRC_APRE: if (tmr_zero) begin
        st_d = DPRC_PRE;
        tmr_d = PRE_LD;
      end
      DPRC_PRE: if (tmr_zero && i_act) begin
        st_d = DPRC_OPEN;
        rst_d = RESTORE_LD;
      end else if (tmr_zero) begin
        st_d = DPRC_IDLE;
      end
      default: st_d = DPRC_IDLE;
    endcase
    // Precharge restarts the period from the latest command
    if (i_pre) begin // R1 R4
      st_d = DPRC_PRE;
      tmr_d = PRE_LD;
    end
    if (i_ref_done) begin // R10
      st_d = DPRC_IDLE;
      tmr_d = '0;
    end
  end

  // State registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= DPRC_IDLE;
      tmr_q <= '0;
      rst_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rst_q <= rst_d;
    end
  end

  // Row stays open until precharge begins
  assign o_open = (st_q == DPRC_OPEN) || (st_q == DPRC_APRE);
  assign o_ready = (st_q == DPRC_IDLE) || (st_q == DPRC_PRE && tmr_zero); // R1

  property p_pre_period;
    @(posedge i_core_clk) disable iff (i_rst)
    i_pre && !i_ref_done |=> !o_ready && !o_open ##1 (o_ready || $past(i_pre));
  endproperty
  a_pre_period: assert property (p_pre_period) else $error("precharge period wrong"); // R4

  property p_ap_hold;
    @(posedge i_core_clk) disable iff (i_rst)
    st_q == DPRC_OPEN && (i_rd || i_wr) && i_ap && !i_pre && !i_ref_done
      |=> st_q == DPRC_APRE && tmr_q >= $past(ap_dly) && tmr_q >= $past(rst_q);
  endproperty
  a_ap_hold: assert property (p_ap_hold) else $error("auto precharge not held back"); // R6
endmodule // dprc_bank

// file: dprc_ctrl.sv
//Function
// R1: Precharge closes row; reopen after precharge period
// R2: Other banks usable during auto precharge
// R3: Controller activates before read or write
// R4: Repeat precharge retimes from latest command
// R5: Read/write with autoprecharge bit closes bank
// R6: Auto precharge waits for restore and write
// R7: Refresh decoded from low select, row, column
// R8: Controller idles all banks before refresh
// R9: Internal row counter gives refresh address
// R10: Refresh end leaves all banks idle
// R11: Only deselect during refresh cycle time
// R12: Postpone at most 8, 16, 32 refreshes
// R13: Refresh gap at most 9, 17, 33 intervals
// R14: Pull in at most 8, 16, 32 refreshes
// R15: At most 16/32/64 refreshes per window
// R16: Controller raises refresh rate when hot
// R17: Mode bit enables temp controlled refresh, range
// R18: Controller keeps range normal when disabled
// R19: Registers every refresh, skips some internally
// R20: Normal range skipping needs no extra control
// R21: Controller spaces activates short or long
// R22: On-the-fly mode samples bank group bit0
// R23: Faster rates use halved or quartered interval
// R24: Per bank open or idle state kept
// R25: Controller keeps clamped refresh credit counter
//
// The address map and the strobed register port are this design's own decisions.
module dprc_ctrl (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Command bus from the memory controller
  input wire logic i_link_clk,
  input wire logic i_cs_n,
  input wire logic i_act_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_bg,
  input wire logic [1:0] i_ba,
  input wire logic [dprc_pkg::AW-1:0] i_addr,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Status
  output logic [dprc_pkg::NBANK-1:0] o_bank_open,
  output logic o_refresh_busy,
  output logic o_refresh_exec,
  output logic [dprc_pkg::ROW_W-1:0] o_refresh_row,
  output logic o_cmd_violation
);
  import dprc_pkg::*;

  logic [PIN_W-1:0] meta_q, sync_q;
  logic ck_prev_q;
  logic busy_q, exec_q, viol_q;
  logic [TW-1:0] rfc_q;
  logic [ROW_W+1:0] row_q;
  logic [2:0] mr3_q;
  logic tcr_en_q, tcr_range_q;
  logic [1:0] zone_q, gear_q;
  logic [15:0] skip_cnt_q;
  logic [31:0] rdata_q;
  logic [NBANK-1:0] open_q;
  logic [NBANK-1:0] open_vec, ready_vec;

  // Two-stage synchroniser for every pin
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      ck_prev_q <= 1'b0;
    end else begin
      meta_q <= {i_link_clk, i_cs_n, i_act_n, i_ras_n, i_cas_n, i_we_n, i_bg, i_ba, i_addr};
      sync_q <= meta_q;
      ck_prev_q <= sync_q[PIN_W-1];
    end
  end

  // Synchronised pin fields
  wire s_ck = sync_q[PIN_W-1];
  wire s_cs_n = sync_q[PIN_W-2];
  wire s_act_n = sync_q[PIN_W-3];
  wire s_ras_n = sync_q[PIN_W-4];
  wire s_cas_n = sync_q[PIN_W-5];
  wire s_we_n = sync_q[PIN_W-6];
  wire [1:0] s_bg = sync_q[AW+3:AW+2];
  wire [1:0] s_ba = sync_q[AW+1:AW];
  wire [AW-1:0] s_addr = sync_q[AW-1:0];
  wire [3:0] bank_idx = {s_bg, s_ba};
  wire s_ap = s_addr[AP_BIT];

  // Command decode on the link clock rising edge
  wire ck_rise = s_ck & ~ck_prev_q;
  wire cmd_v = ck_rise & ~s_cs_n;
  wire nact = cmd_v & s_act_n;
  wire act_c = cmd_v & ~s_act_n;
  wire ref_c = nact & ~s_ras_n & ~s_cas_n & s_we_n; // R7
  wire pre_c = nact & ~s_ras_n & s_cas_n & ~s_we_n;
  wire wr_c = nact & s_ras_n & ~s_cas_n & ~s_we_n;
  wire rd_c = nact & s_ras_n & ~s_cas_n & s_we_n;
  wire mrs_c = nact & ~s_ras_n & ~s_cas_n & ~s_we_n;

  // Bank lookups for the addressed bank, and whether all banks are ready
  wire tgt_open = open_vec[bank_idx];
  wire tgt_ready = ready_vec[bank_idx];
  wire all_ready = &ready_vec;

  // Commands during refresh, and activates or accesses to banks in a wrong state, are dropped
  wire act_ok = act_c & ~busy_q & tgt_ready;
  wire pre_ok = pre_c & ~busy_q;
  wire rw_ok = (rd_c | wr_c) & ~busy_q & tgt_open; // R2
  wire ref_ok = ref_c & ~busy_q;
  wire mrs_ok = mrs_c & ~busy_q;

  // Rule breaks by the controller raise a sticky flag
  wire bad_busy = busy_q & (act_c | pre_c | rd_c | wr_c | ref_c | mrs_c); // R11
  wire bad_rw = (rd_c | wr_c) & ~busy_q & ~tgt_open; // R3
  wire bad_act = act_c & ~busy_q & ~tgt_ready; // R1
  wire bad_ref = ref_ok & ~all_ready; // R8
  wire viol_set = bad_busy | bad_rw | bad_act | bad_ref;

  // Refresh end
  wire rfc_zero = (rfc_q == '0);
  wire ref_done = busy_q & rfc_zero;

  // Per-bank state machines
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    wire hit = (bank_idx == 4'(b));
    dprc_bank u_bank (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_act(act_ok & hit),
      .i_pre(pre_ok & (hit | s_ap)), // R1
      .i_rd(rw_ok & rd_c & hit),
      .i_wr(rw_ok & wr_c & hit),
      .i_ap(s_ap), // R5
      .i_ref_done(ref_done), // R10
      .o_open(open_vec[b]),
      .o_ready(ready_vec[b])
    );
  end

  // Bank of the latest auto precharge access, watched until it closes
  logic [3:0] ap_bank_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ap_bank_q <= 4'h0;
    end else if (rw_ok && s_ap) begin
      ap_bank_q <= bank_idx;
    end
  end
  wire ap_bank_open = open_vec[ap_bank_q];

  // Refresh rate: fixed from mode, or picked per command by bank group bit0
  wire otf = mr3_q[2] & (mr3_q[1] ^ mr3_q[0]); // Reserved codes run as 1x
  wire [1:0] otf_rate = (mr3_q == MR3_OTF12) ? RATE_2X : RATE_4X;
  wire [1:0] eff_rate = !otf ? mr3_q[1:0] : (s_bg[0] ? otf_rate : RATE_1X); // R22
  wire [TW-1:0] rfc_ld = (eff_rate == RATE_2X) ? RFC2_LD :
                         (eff_rate == RATE_4X) ? RFC4_LD : RFC1_LD;
  wire [ROW_W+1:0] step = (eff_rate == RATE_2X) ? STEP_2X :
                          (eff_rate == RATE_4X) ? STEP_4X : STEP_1X;

  // Temperature controlled skipping: cool case runs one of two refreshes
  wire skip_zone = tcr_en_q & (zone_q == ZONE_COOL); // R20
  wire ref_exec = ~skip_zone | (gear_q == GEAR_LAST); // R19

  // Refresh sequencer and internal row counter
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      rfc_q <= '0;
      row_q <= '0;
      gear_q <= '0;
      exec_q <= 1'b0;
      skip_cnt_q <= '0;
    end else begin
      exec_q <= ref_ok & ref_exec;
      if (ref_ok) begin // R7
        busy_q <= 1'b1;
        rfc_q <= rfc_ld;
        gear_q <= (skip_zone && gear_q != GEAR_LAST) ? gear_q + 2'h1 : 2'h0;
        if (ref_exec) begin
          row_q <= row_q + step; // R9
        end else begin
          skip_cnt_q <= skip_cnt_q + 16'h0001; // R19
        end
      end else if (ref_done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        rfc_q <= rfc_q - 1'b1;
      end
    end
  end

  // Mode register writes carried on the command bus
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mr3_q <= 3'h0;
      tcr_en_q <= 1'b0;
      tcr_range_q <= 1'b0;
    end else if (mrs_ok && bank_idx == MR_SEL_THREE) begin
      mr3_q <= s_addr[MR3_RATE_LSB+2:MR3_RATE_LSB];
    end else if (mrs_ok && bank_idx == MR_SEL_FOUR) begin
      tcr_en_q <= s_addr[MR4_TCR_BIT]; // R17
      tcr_range_q <= s_addr[MR4_RANGE_BIT]; // R17
    end
  end

  // Register write decode
  wire wr_ctrl = i_reg_wr & (i_reg_addr == REG_CTRL);
  wire wr_stat = i_reg_wr & (i_reg_addr == REG_STAT);
  wire viol_clr = wr_stat & i_reg_wdata[ST_VIOL];

  // Control register and sticky violation flag, set beats clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      zone_q <= CTRL_RST;
      viol_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        zone_q <= i_reg_wdata[1:0];
      end
      viol_q <= viol_set | (viol_q & ~viol_clr);
    end
  end

  // Read data selection
  wire [31:0] stat_word = {9'h000, viol_q, mr3_q, tcr_range_q, tcr_en_q, busy_q, open_q};
  wire [31:0] rd_mux = (i_reg_addr == REG_CTRL) ? {30'h00000000, zone_q} :
                       (i_reg_addr == REG_STAT) ? stat_word :
                       (i_reg_addr == REG_ROW) ? {14'h0000, row_q[ROW_W+1:2]} :
                       (i_reg_addr == REG_SKIP) ? {16'h0000, skip_cnt_q} : 32'h00000000;

  // Read data for one cycle, bank state snapshot
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h00000000;
      open_q <= '0;
    end else begin
      rdata_q <= i_reg_rd ? rd_mux : 32'h00000000;
      open_q <= open_vec; // R24
    end
  end

  // Outputs
  assign o_reg_rdata = rdata_q;
  assign o_bank_open = open_q;
  assign o_refresh_busy = busy_q;
  assign o_refresh_exec = exec_q;
  assign o_refresh_row = row_q[ROW_W+1:2];
  assign o_cmd_violation = viol_q;

  property p_ref_busy;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok |=> o_refresh_busy [*8];
  endproperty
  a_ref_busy: assert property (p_ref_busy) else $error("refresh not taken"); // R7

  property p_row_step;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok && ref_exec |=> row_q == $past(row_q) + $past(step) && o_refresh_exec;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row counter did not advance"); // R9

  property p_row_ext;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok |=> row_q == $past(row_q) || row_q == $past(row_q) + $past(step);
  endproperty
  a_row_ext: assert property (p_row_ext) else $error("refresh row not from counter"); // R9

  property p_skip_hold;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok && !ref_exec |=> $stable(row_q) && !o_refresh_exec && o_refresh_busy;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skipped refresh moved row"); // R19

  property p_no_skip;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok && !tcr_en_q |=> o_refresh_exec;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip with mode off"); // R17

  property p_ref_idle;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_done |=> !o_refresh_busy ##1 o_bank_open == '0;
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("bank open after refresh"); // R10

  property p_pre_all;
    @(posedge i_core_clk) disable iff (i_rst)
    pre_ok && s_ap |-> ##2 o_bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge left a row open"); // R1

  property p_mr4;
    @(posedge i_core_clk) disable iff (i_rst)
    mrs_ok && bank_idx == MR_SEL_FOUR |=> tcr_en_q == $past(s_addr[MR4_TCR_BIT])
      && tcr_range_q == $past(s_addr[MR4_RANGE_BIT]);
  endproperty
  a_mr4: assert property (p_mr4) else $error("mode bits not stored"); // R17

  property p_otf;
    @(posedge i_core_clk) disable iff (i_rst)
    ref_ok && otf && s_bg[0] |-> eff_rate != RATE_1X && rfc_ld != RFC1_LD;
  endproperty
  a_otf: assert property (p_otf) else $error("fast refresh not selected"); // R22

  property p_bad_rw;
    @(posedge i_core_clk) disable iff (i_rst)
    bad_rw |=> o_cmd_violation;
  endproperty
  a_bad_rw: assert property (p_bad_rw) else $error("access to idle bank not flagged"); // R3

  property p_bad_act;
    @(posedge i_core_clk) disable iff (i_rst)
    bad_act |=> o_cmd_violation;
  endproperty
  a_bad_act: assert property (p_bad_act) else $error("early activate not flagged"); // R1

  property p_busy_viol;
    @(posedge i_core_clk) disable iff (i_rst)
    bad_busy |=> o_cmd_violation && o_refresh_busy;
  endproperty
  a_busy_viol: assert property (p_busy_viol) else $error("command in refresh not flagged"); // R11

  property p_ap_close;
    @(posedge i_core_clk) disable iff (i_rst)
    rw_ok && s_ap |=> ##[0:7] !ap_bank_open;
  endproperty
  a_ap_close: assert property (p_ap_close) else $error("auto precharge left the bank open"); // R5

  property p_rdata_once;
    @(posedge i_core_clk) disable iff (i_rst)
    !i_reg_rd |=> o_reg_rdata == 32'h00000000;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("read data outside its cycle");

  c_ref_exec: cover property (@(posedge i_core_clk) disable iff (i_rst) ref_ok && ref_exec);
  c_ref_skip: cover property (@(posedge i_core_clk) disable iff (i_rst) ref_ok && !ref_exec);
  c_auto_pre: cover property (@(posedge i_core_clk) disable iff (i_rst) rw_ok && s_ap);
  c_otf_ref: cover property (@(posedge i_core_clk) disable iff (i_rst) ref_ok && otf && s_bg[0]);
  c_pre_all: cover property (@(posedge i_core_clk) disable iff (i_rst) pre_ok && s_ap);
endmodule // dprc_ctrl

// file: dprc_mc_model.sv
module dprc_mc_model (
  // Command bus to the device
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_act_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_bg,
  output logic [1:0] o_ba,
  output logic [dprc_pkg::AW-1:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dprc_pkg::*;
  logic rel_q = 1'b0;
  // Refresh pacing: booked at one average interval each, at most 8 ahead, 16 per two intervals
  localparam logic [4:0] CMD_REF = 5'h09;
  localparam real REFI_NS = 7800.0;
  localparam int PULL_IN = 8;
  localparam int WIN_REFS = 16;
  int n_ref = 0;
  real last_ref = -1.0e6;
  // Free running command clock, 160 ns
  initial begin
    o_link_clk = 1'b0;
    forever #80 o_link_clk = ~o_link_clk;
  end
  // Bus starts deselected
  initial begin
    {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = 5'h1F;
    o_bg = 2'h0;
    o_ba = 2'h0;
    o_addr = '0;
  end
  // Deselect after use; scramble the don't-care pins so stale values never help
  always @(negedge o_link_clk) begin
    if (rel_q) begin
      o_cs_n <= 1'b1;
      {o_act_n, o_ras_n, o_cas_n, o_we_n} <= ~{o_act_n, o_ras_n, o_cas_n, o_we_n};
      o_bg <= ~o_bg;
      o_ba <= ~o_ba;
      o_addr <= ~o_addr;
      rel_q <= 1'b0;
    end
  end
  // One command per clock, driven on the fall, held across the rise
  task automatic send(input logic [4:0] c, input logic [1:0] g, input logic [1:0] b, input logic [AW-1:0] a);
    real t_ok;
    t_ok = 0.0;
    // Hold a refresh back until the pull-in and window limits allow it
    if (c == CMD_REF) begin
      if (n_ref > PULL_IN) t_ok = (n_ref - PULL_IN) * REFI_NS;
      if (last_ref + 2.0 * REFI_NS / WIN_REFS > t_ok) t_ok = last_ref + 2.0 * REFI_NS / WIN_REFS;
      if (t_ok > $realtime) #(t_ok - $realtime);
      n_ref++;
    end
    @(negedge o_link_clk);
    #1;
    {o_cs_n, o_act_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_bg = g;
    o_ba = b;
    o_addr = a;
    @(posedge o_link_clk);
    if (c == CMD_REF) last_ref = $realtime;
    rel_q = 1'b1;
  endtask
endmodule // dprc_mc_model

// file: dprc_pkg.sv
package dprc_pkg;
  // Core clock period
  localparam int CLK_PS = 10000;
  // Timing figures in picoseconds
  localparam int PRE_PS = 13750;
  localparam int RESTORE_PS = 32000;
  localparam int AP_RD_PS = 7500;
  localparam int AP_WR_PS = 45000;
  localparam int RFC1_PS = 350000;
  localparam int RFC2_PS = 260000;
  localparam int RFC4_PS = 160000;
  // Least times rounded up to core cycles
  localparam int PRE_CYC = (PRE_PS + CLK_PS - 1) / CLK_PS;
  localparam int RESTORE_CYC = (RESTORE_PS + CLK_PS - 1) / CLK_PS;
  localparam int AP_RD_CYC = (AP_RD_PS + CLK_PS - 1) / CLK_PS;
  localparam int AP_WR_CYC = (AP_WR_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC1_CYC = (RFC1_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC2_CYC = (RFC2_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC4_CYC = (RFC4_PS + CLK_PS - 1) / CLK_PS;
  // Timer loads
  localparam int TW = 8;
  localparam logic [TW-1:0] PRE_LD = TW'(PRE_CYC - 1);
  localparam logic [TW-1:0] RESTORE_LD = TW'(RESTORE_CYC - 1);
  localparam logic [TW-1:0] AP_RD_LD = TW'(AP_RD_CYC - 1);
  localparam logic [TW-1:0] AP_WR_LD = TW'(AP_WR_CYC - 1);
  localparam logic [TW-1:0] RFC1_LD = TW'(RFC1_CYC - 1);
  localparam logic [TW-1:0] RFC2_LD = TW'(RFC2_CYC - 1);
  localparam logic [TW-1:0] RFC4_LD = TW'(RFC4_CYC - 1);
  // Geometry
  localparam int NBANK = 16;
  localparam int AW = 18;
  localparam int ROW_W = 18;
  localparam int AP_BIT = 10;
  localparam int PIN_W = 1 + 5 + 4 + AW;
  // Mode register selects and fields
  localparam logic [3:0] MR_SEL_THREE = 4'h3;
  localparam logic [3:0] MR_SEL_FOUR = 4'h4;
  localparam int MR4_TCR_BIT = 3;
  localparam int MR4_RANGE_BIT = 2;
  localparam int MR3_RATE_LSB = 6;
  localparam logic [2:0] MR3_OTF12 = 3'h5;
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;
  // Row counter steps in quarter rows
  localparam logic [ROW_W+1:0] STEP_1X = 20'h00004;
  localparam logic [ROW_W+1:0] STEP_2X = 20'h00002;
  localparam logic [ROW_W+1:0] STEP_4X = 20'h00001;
  // Internal refresh gear: one of GEAR refreshes executed when cool
  localparam logic [1:0] GEAR_LAST = 2'h1;
  localparam logic [1:0] ZONE_COOL = 2'h0;
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ROW = 8'h08;
  localparam logic [7:0] REG_SKIP = 8'h0C;
  localparam int ST_BUSY = 16;
  localparam int ST_TCR = 17;
  localparam int ST_RANGE = 18;
  localparam int ST_MODE = 19;
  localparam int ST_VIOL = 22;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Bank states
  typedef enum logic [3:0] {
    DPRC_IDLE = 4'b0001,
    DPRC_OPEN = 4'b0010,
    DPRC_APRE = 4'b0100,
    DPRC_PRE = 4'b1000
  } dprc_bank_t;
endpackage

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dprc_pkg::*;
  // Command codes as {select, activate, row, column, write} strobes
  localparam logic [4:0] C_ACT = 5'h00;
  localparam logic [4:0] C_PRE = 5'h0A;
  localparam logic [4:0] C_RD = 5'h0D;
  localparam logic [4:0] C_WR = 5'h0C;
  localparam logic [4:0] C_REF = 5'h09;
  localparam logic [4:0] C_MODE = 5'h08;
  // Rate mode walk and bank group bit0 per step
  localparam logic [2:0] RMODE [10] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h5, 3'h5, 3'h6, 3'h4, 3'h7, 3'h3};
  localparam logic [9:0] RSEL = 10'h1D0;
  logic i_core_clk;
  logic i_rst;
  wire link_clk, cs_n, act_n, ras_n, cas_n, we_n;
  wire [1:0] bg, ba;
  wire [AW-1:0] addr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [NBANK-1:0] bank_open;
  logic busy, exec, viol;
  logic [ROW_W-1:0] row;
  int err_total = 0;
  int n_tests = 0;
  int n, nb, ne, q, st, rf;
  // Core clock, 100 MHz
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  dprc_mc_model mc (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_act_n(act_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_bg(bg), .o_ba(ba), .o_addr(addr));
  dprc_ctrl uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_cs_n(cs_n),
    .i_act_n(act_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bg(bg), .i_ba(ba),
    .i_addr(addr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_bank_open(bank_open), .o_refresh_busy(busy),
    .o_refresh_exec(exec), .o_refresh_row(row), .o_cmd_violation(viol));
  // Verdict and end of run
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Register port: one-cycle strobes, read data in the following cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge i_core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  // Command, then wait out synchroniser and state update
  task automatic issue(input logic [4:0] c, input logic [1:0] g, input logic [1:0] b, input logic [AW-1:0] a);
    mc.send(c, g, b, a);
    repeat (6) @(posedge i_core_clk);
    #1;
  endtask
  // Refresh; count busy cycles and executed pulses
  task automatic refr(input logic b0, output int bsy, output int ex);
    bsy = 0;
    ex = 0;
    mc.send(C_REF, {1'b0, b0}, 2'h0, 18'h2AAAA);
    repeat (60) begin
      @(posedge i_core_clk);
      #1;
      bsy += int'(busy === 1'b1);
      ex += int'(exec === 1'b1);
    end
  endtask
  task automatic reps(input int k, input int want, input string nm);
    int s;
    s = 0;
    repeat (k) begin
      refr(1'b0, nb, ne);
      s += ne;
    end
    chk(nm, want, s);
  endtask
  // Cycles from command clock rise until a bank closes
  task automatic fall(input int b, output int k);
    k = 0;
    while (bank_open[b] !== 1'b0 && k < 40) begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    if (k == 40) begin
      err_total++;
      $display("MISMATCH bank_close expected 0 seen 1");
      test_done();
    end
  endtask
  // Main sequence
  initial begin
    i_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q = 0;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    reg_write(REG_STAT, 32'h0000FFFF);
    reg_write(8'h10, 32'hFFFFFFFF);
    for (int a = 0; a < 5; a++) reg_read(8'(a * 4), 32'h0, "reset_value");
    reg_write(REG_CTRL, 32'h2);
    reg_read(REG_CTRL, 32'h2, "ctrl_rw");
    reg_write(REG_CTRL, 32'h0);
    // Open, close, close again while idle, reopen
    issue(C_ACT, 2'h1, 2'h1, 18'h00123);
    chk("open_act", 32'h20, bank_open);
    issue(C_PRE, 2'h1, 2'h1, 18'h00000);
    chk("open_pre", 32'h0, bank_open);
    issue(C_PRE, 2'h1, 2'h1, 18'h00000);
    issue(C_ACT, 2'h1, 2'h1, 18'h00123);
    chk("reopen", 32'h20, bank_open);
    chk("no_violation", 32'h0, viol);
    // Auto close after write and read, another group stays usable
    issue(C_ACT, 2'h0, 2'h0, 18'h00055);
    mc.send(C_WR, 2'h1, 2'h1, 18'h00400);
    fall(5, n);
    chk("wr_close_delay", 32'h1, n >= AP_WR_CYC + 2 && n <= AP_WR_CYC + 9);
    chk("other_open", 32'h1, bank_open);
    mc.send(C_RD, 2'h0, 2'h0, 18'h00400);
    fall(0, n);
    chk("rd_close_delay", 32'h1, n >= AP_RD_CYC + 2 && n <= AP_RD_CYC + 9);
    chk("no_violation", 32'h0, viol);
    issue(C_RD, 2'h0, 2'h0, 18'h00000);
    chk("viol_closed_rd", 32'h1, viol);
    reg_write(REG_STAT, 32'h00400000);
    reg_read(REG_STAT, 32'h0, "viol_clear");
    // All-bank precharge
    issue(C_ACT, 2'h0, 2'h2, 18'h00000);
    issue(C_ACT, 2'h3, 2'h3, 18'h00000);
    chk("two_open", 32'h8004, bank_open);
    issue(C_PRE, 2'h0, 2'h0, 18'h00400);
    chk("pre_all", 32'h0, bank_open);
    // Every rate mode; address pins carry junk
    for (int i = 0; i < 10; i++) begin
      issue(C_MODE, 2'h0, 2'h3, 18'(RMODE[i]) << 6);
      if (RMODE[i] == 3'h1 || (RMODE[i] == 3'h5 && RSEL[i])) begin
        st = 2;
        rf = RFC2_CYC;
      end else if (RMODE[i] == 3'h2 || (RMODE[i] == 3'h6 && RSEL[i])) begin
        st = 1;
        rf = RFC4_CYC;
      end else begin
        st = 4;
        rf = RFC1_CYC;
      end
      q += st;
      refr(RSEL[i], nb, ne);
      chk("busy_cycles", rf, nb);
      chk("exec_pulses", 1, ne);
      chk("refresh_row", q >> 2, row);
    end
    reg_read(REG_STAT, 32'h00180000, "rate_field");
    // Command inside refresh cycle time is dropped
    mc.send(C_REF, 2'h0, 2'h0, 18'h00000);
    issue(C_ACT, 2'h0, 2'h2, 18'h00000);
    chk("act_in_refresh", 32'h0, bank_open);
    chk("viol_in_refresh", 32'h1, viol);
    repeat (40) @(posedge i_core_clk);
    reg_write(REG_STAT, 32'h00400000);
    issue(C_ACT, 2'h0, 2'h3, 18'h00000);
    chk("open3", 32'h8, bank_open);
    refr(1'b0, nb, ne);
    chk("idle_after_ref", 32'h0, bank_open);
    chk("viol_ref_open", 32'h1, viol);
    reg_write(REG_STAT, 32'h00400000);
    // Temperature controlled refresh in both ranges and zones
    issue(C_MODE, 2'h1, 2'h0, 18'h00008);
    reg_read(REG_STAT, 32'h001A0000, "tcr_on");
    reps(4, 2, "exec_cool");
    reg_read(REG_SKIP, 32'h2, "skip_count");
    issue(C_MODE, 2'h1, 2'h0, 18'h0000C);
    reg_read(REG_STAT, 32'h001E0000, "tcr_ext");
    reps(2, 1, "exec_cool_ext");
    reg_write(REG_CTRL, 32'h1);
    reps(2, 2, "exec_warm");
    issue(C_MODE, 2'h1, 2'h0, 18'h00000);
    reg_read(REG_STAT, 32'h00180000, "tcr_off");
    reg_write(REG_CTRL, 32'h0);
    reps(2, 2, "exec_off");
    test_done();
  end
endmodule // testbench
